// [test/capcmp_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module capcmp_checker (
   input wire logic               clk_in,
   input wire logic               rst_n_in,
   input wire logic               psel_in,
   input wire logic               penable_in,
   input wire logic               pwrite_in,
   input wire logic [12:0]        paddr_in,
   input wire logic [31:0]        pwdata_in,
   input wire logic [31:0]        prdata_out,
   input wire capcmp_pkg::value_t first_wide_timer_in,
   input wire logic [1:0]         wide_timer_clear_out,
   input wire logic [1:0]         input_remap_pin_in,
   input wire logic [1:0]         chan_out,
   input wire logic [1:0]         chan_irq_flag_out
);
   import capcmp_pkg::*;
   logic [7:0] ctrl_reg, trig_reg, tsel_reg;
   value_t     val_reg;
   logic       wr;
   assign wr = psel_in && penable_in && pwrite_in;
   // Shadows of the fields the checks depend on
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_reg <= 8'h00;
         trig_reg <= 8'h00;
         tsel_reg <= 8'h05;
      end else if (wr) begin
         if (paddr_in == 13'h1038) ctrl_reg <= pwdata_in[7:0] & 8'h9f;
         if (paddr_in == 13'h103c) trig_reg <= pwdata_in[7:0];
         if (paddr_in == 13'h107c) tsel_reg <= pwdata_in[7:0];
      end
   end
   always_ff @(posedge clk_in) begin
      if (wr && paddr_in == 13'h1030) val_reg <= pwdata_in[15:0];
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   chk_off_quiet: assert property (
      $past(ctrl_reg[3:0]) == 4'h0 |-> !chan_irq_flag_out[0]) else $error("irq while off");
   chk_off_low: assert property (
      ($past(ctrl_reg[3:0]) == 4'h0 || !$past(ctrl_reg[7])) |-> !chan_out[0])
      else $error("output high while off");
   chk_clear_once: assert property (
      wide_timer_clear_out[0] |=> !wide_timer_clear_out[0]) else $error("clear pulse too long");
   chk_clear_route: assert property (
      wide_timer_clear_out[1] |-> $past(tsel_reg[1:0]) == 2'h2 || $past(tsel_reg[3:2]) == 2'h2)
      else $error("second timer cleared but not selected");
   chk_cap_rise: assert property (
      ctrl_reg == 8'h85 && trig_reg[3:0] == 4'h0 && $rose(input_remap_pin_in[0])
      |-> ##[2:4] chan_irq_flag_out[0]) else $error("rising capture missed");
   chk_pulse_one: assert property (
      ctrl_reg[7] && ctrl_reg[3:1] == 3'b101 && $rose(chan_out[0]) |=> !chan_out[0])
      else $error("pulse longer than one cycle");
   chk_match_set: assert property (
      ctrl_reg == 8'h88 && tsel_reg[1:0] != 2'h2 && first_wide_timer_in == val_reg
      && $past(first_wide_timer_in) != val_reg |=> chan_out[0] && chan_irq_flag_out[0])
      else $error("match did not set output");
   chk_out_read: assert property (
      psel_in && penable_in && !pwrite_in && paddr_in == 13'h1038
      |-> prdata_out[5] == $past(chan_out[0]) && !prdata_out[6]) else $error("bad level readback");
endmodule
bind capture_compare_pwm_mode_control capcmp_checker chk (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
   .first_wide_timer_in(first_wide_timer_in), .wide_timer_clear_out(wide_timer_clear_out),
   .input_remap_pin_in(input_remap_pin_in), .chan_out(chan_out),
   .chan_irq_flag_out(chan_irq_flag_out));
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import capcmp_pkg::*;
   logic        clk_in, rst_n_in, psel, penable, pwrite, run, pready, pslverr, np, e;
   logic [12:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0]  src;
   logic [1:0]  clr, cout, irq;
   value_t      t1, t2, tv;
   duty_t       nb;
   int          err_count, n_compared, irqs, clr0, clr1, hi, n0, c0, c1, h1, h2, h3;
   logic [3:0]  cmd [7] = '{4'h8, 4'h2, 4'h1, 4'h9, 4'ha, 4'hb, 4'h1};
   int          lvl [7] = '{1, 0, 1, 0, 1, 1, 1};
   int          clx [7] = '{0, 0, 1, 0, 0, 1, 2};
   int          ncap [5] = '{32, 16, 16, 4, 1};
   always #20 clk_in = ~clk_in;
   capture_compare_pwm_mode_control DUT (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .first_wide_timer_in(t1),
      .second_wide_timer_in(t2), .first_narrow_base_in(nb), .second_narrow_base_in(nb),
      .first_narrow_period_in(np), .second_narrow_period_in(np),
      .wide_timer_clear_out(clr), .input_remap_pin_in({2{src[0]}}),
      .comparator_one_result_in(src[1]), .comparator_two_result_in(src[2]),
      .pin_change_interrupt_in(src[3]), .logic_cell_result_in(src[7:4]),
      .chan_out(cout), .chan_irq_flag_out(irq));
   timer_source_model partner (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(run), .clear_in(clr),
      .wide1_out(t1), .wide2_out(t2), .base_out(nb), .period_out(np));
   // Outputs are counted mid-cycle, away from the edge that launches them
   always @(negedge clk_in) begin
      if (irq[0] === 1'b1) irqs++;
      if (clr[0] === 1'b1) clr0++;
      if (clr[1] === 1'b1) clr1++;
      if (cout[0] === 1'b1) hi++;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [12:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      check(q, x);
   endtask
   task automatic pulse(input int k);
      src[k] <= 1'b1;
      repeat (4) @(posedge clk_in);
      src[k] <= 1'b0;
      repeat (6) @(posedge clk_in);
   endtask
   task automatic meas(input logic [7:0] c, input logic [15:0] v, output int h);
      int i0;
      apb(1'b1, 13'h1030, {16'h0, v});
      apb(1'b1, 13'h1038, {24'h0, c});
      repeat (130) @(posedge clk_in);
      h = hi;
      i0 = irqs;
      repeat (64) @(posedge clk_in);
      h = hi - h;
      check(32'(irqs - i0), 32'h1);
   endtask
   initial begin
      repeat (10000) @(posedge clk_in);
      err_count++;
      give_verdict;
   end
   initial begin
      clk_in = 1'b0;
      rst_n_in = 1'b0;
      {psel, penable, pwrite, run} = 4'h0;
      paddr = 13'h0000;
      pwdata = 32'h0;
      src = 8'h00;
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rdc(13'h1038, 32'h0);
      rdc(13'h103c, 32'h0);
      rdc(13'h107c, 32'h5);
      apb(1'b1, 13'h1034, 32'h1);
      check(32'(e), 32'h1);
      apb(1'b1, 13'h1040, 32'h1234);
      rdc(13'h1040, 32'h1234);
      apb(1'b1, 13'h1038, 32'h7f);
      rdc(13'h1038, 32'h1f);
      apb(1'b1, 13'h107c, 32'h9);
      rdc(13'h107c, 32'h9);
      apb(1'b1, 13'h1038, 32'h0);
      for (int i = 0; i < 7; i++) begin
         run <= 1'b0;
         @(posedge clk_in);
         apb(1'b1, 13'h107c, (i == 6) ? 32'h6 : 32'h5);
         tv = (i == 6) ? t2 : t1;
         apb(1'b1, 13'h1030, {16'h0, tv + 16'h0008});
         c0 = clr0;
         c1 = clr1;
         apb(1'b1, 13'h1038, {24'h0, 4'h8, cmd[i]});
         run <= 1'b1;
         n0 = 0;
         do begin
            @(negedge clk_in);
            n0++;
         end while (irq[0] !== 1'b1 && n0 < 100);
         check(32'(irq[0]), 32'h1);
         check(32'(cout[0]), 32'(lvl[i]));
         repeat (3) @(posedge clk_in);
         check(32'((clr1 - c1) * 2 + clr0 - c0), 32'(clx[i]));
      end
      run <= 1'b0;
      apb(1'b1, 13'h1038, 32'h01);
      rdc(13'h1038, 32'h01);
      apb(1'b1, 13'h107c, 32'h5);
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, 13'h1038, 32'h0);
         run <= 1'b1;
         repeat (3) @(posedge clk_in);
         run <= 1'b0;
         @(posedge clk_in);
         tv = t1;
         n0 = irqs;
         apb(1'b1, 13'h1038, {24'h0, 4'h8, 4'(i + 3)});
         repeat (16) pulse(0);
         check(32'(irqs - n0), 32'(ncap[i]));
         rdc(13'h1030, {16'h0, tv});
      end
      apb(1'b1, 13'h1038, 32'h85);
      for (int k = 0; k < 9; k++) begin
         apb(1'b1, 13'h103c, 32'(k));
         n0 = irqs;
         pulse((k < 8) ? k : 0);
         check(32'(irqs - n0), (k < 8) ? 32'h1 : 32'h0);
      end
      meas(8'h8c, 16'hfc0a, h1);
      meas(8'h9f, 16'h02bf, h2);
      meas(8'h8e, 16'h0014, h3);
      check(32'(h2), 32'(h1));
      check(32'(h3 - h1), 32'd10);
      apb(1'b1, 13'h1030, 32'h5aa5);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rdc(13'h1030, 32'h5aa5);
      rdc(13'h107c, 32'h5);
      give_verdict;
   end
endmodule
`default_nettype wire

// [test/timer_source_model.sv]
`timescale 1ns/100ps
`default_nettype none
module timer_source_model #(
   parameter logic [9:0] LAST = 10'h03f
) (
   // Clock and reset
   input  wire logic          clk_in,
   input  wire logic          rst_n_in,
   // Control from the bench and the channel
   input  wire logic          run_in,
   input  wire logic [1:0]    clear_in,
   // Timer values
   output var capcmp_pkg::value_t wide1_out,
   output var capcmp_pkg::value_t wide2_out,
   output var capcmp_pkg::duty_t  base_out,
   output logic               period_out
);
   import capcmp_pkg::*;
   // Narrow base runs free; its period is LAST+1 cycles
   assign period_out = (base_out == LAST);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wide1_out <= 16'h0000;
         wide2_out <= 16'h8000;
         base_out <= 10'h000;
      end else begin
         base_out <= period_out ? 10'h000 : base_out + 10'h001;
         if (clear_in[0]) wide1_out <= 16'h0000;
         else if (run_in) wide1_out <= wide1_out + 16'h0001;
         if (clear_in[1]) wide2_out <= 16'h0000;
         else if (run_in) wide2_out <= wide2_out + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// [verilog/capcmp_pkg.sv]
package capcmp_pkg;
   typedef logic [3:0]  mode_t;
   typedef logic [15:0] value_t;
   typedef logic [9:0]  duty_t;
   typedef enum logic [1:0] {
      CLASS_OFF,
      CLASS_CAPTURE,
      CLASS_COMPARE,
      CLASS_PWM
   } chan_class_e;
endpackage

// [verilog/capcmp_regs.svh]
`ifndef CAPCMP_REGS_SVH
`define CAPCMP_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_CH1_VALUE        11'h40c
`define IDX_CH1_CONTROL      11'h40e
`define IDX_CH1_TRIGGER      11'h40f
`define IDX_CH2_VALUE        11'h410
`define IDX_CH2_CONTROL      11'h412
`define IDX_CH2_TRIGGER      11'h413
`define IDX_TIMER_SELECT     11'h41f

// Control register fields
`define CTRL_EN_BIT          7
`define CTRL_OUT_BIT         5
`define CTRL_ALIGN_BIT       4
`define CTRL_RESET           8'h00
`define CTRL_WR_MASK         8'h9f

// Trigger select and timer select
`define TRIG_RESET           4'h0
`define TSEL_RESET           8'h05
`define TSEL_SECOND          2'h2

// Mode encodings
`define MODE_OFF             4'h0
`define MODE_TOG_CLR         4'h1
`define MODE_TOGGLE          4'h2
`define MODE_CAP_ANY         4'h3
`define MODE_CAP_FALL        4'h4
`define MODE_CAP_RISE        4'h5
`define MODE_CAP_RISE4       4'h6
`define MODE_CAP_RISE16      4'h7
`define MODE_SET             4'h8
`define MODE_CLEAR           4'h9
`define MODE_PULSE           4'ha
`define MODE_PULSE_CLR       4'hb

// Prescale terminal counts
`define PRESC_LAST4          4'h3
`define PRESC_LAST16         4'hf

`endif

// [verilog/capture_compare_pwm_mode_control.sv]
`include "capcmp_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module capture_compare_pwm_mode_control (
   // Clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    rst_n_in,
   // APB slave
   input  wire logic                    psel_in,
   input  wire logic                    penable_in,
   input  wire logic                    pwrite_in,
   input  wire logic [12:0]             paddr_in,
   input  wire logic [31:0]             pwdata_in,
   output logic      [31:0]             prdata_out,
   output logic                         pready_out,
   output logic                         pslverr_out,
   // Timers
   input  wire capcmp_pkg::value_t      first_wide_timer_in,
   input  wire capcmp_pkg::value_t      second_wide_timer_in,
   input  wire capcmp_pkg::duty_t       first_narrow_base_in,
   input  wire capcmp_pkg::duty_t       second_narrow_base_in,
   input  wire logic                    first_narrow_period_in,
   input  wire logic                    second_narrow_period_in,
   output logic      [1:0]              wide_timer_clear_out,
   // Trigger sources
   input  wire logic [1:0]              input_remap_pin_in,
   input  wire logic                    comparator_one_result_in,
   input  wire logic                    comparator_two_result_in,
   input  wire logic                    pin_change_interrupt_in,
   input  wire logic [3:0]              logic_cell_result_in,
   // Channel outputs
   output logic      [1:0]              chan_out,
   output logic      [1:0]              chan_irq_flag_out
);
   import capcmp_pkg::*;

   logic [7:0]  ctrl_reg [2];
   logic [3:0]  trig_reg [2];
   value_t      value_reg [2];
   logic [7:0]  tsel_reg;
   logic [1:0]  out_reg;
   logic [1:0]  irq_reg;
   logic [1:0]  clr_req_reg [2];
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic [8:0]  sync1_reg;
   logic [8:0]  sync2_reg;

   // Bus decode
   wire         setup_w   = psel_in & ~penable_in;
   wire         access_w  = psel_in & penable_in;
   wire         wr_w      = access_w & pwrite_in;
   wire [10:0]  idx_w     = paddr_in[12:2];
   wire         al_ok_w   = (paddr_in[1:0] == 2'h0);
   wire         hit_v1_w  = al_ok_w & (idx_w == `IDX_CH1_VALUE);
   wire         hit_c1_w  = al_ok_w & (idx_w == `IDX_CH1_CONTROL);
   wire         hit_t1_w  = al_ok_w & (idx_w == `IDX_CH1_TRIGGER);
   wire         hit_v2_w  = al_ok_w & (idx_w == `IDX_CH2_VALUE);
   wire         hit_c2_w  = al_ok_w & (idx_w == `IDX_CH2_CONTROL);
   wire         hit_t2_w  = al_ok_w & (idx_w == `IDX_CH2_TRIGGER);
   wire         hit_ts_w  = al_ok_w & (idx_w == `IDX_TIMER_SELECT);
   wire         mapped_w  = hit_v1_w | hit_c1_w | hit_t1_w | hit_v2_w |
                            hit_c2_w | hit_t2_w | hit_ts_w;
   wire [1:0]   wr_val_w  = {wr_w & hit_v2_w, wr_w & hit_v1_w};
   wire [1:0]   wr_ctl_w  = {wr_w & hit_c2_w, wr_w & hit_c1_w};
   wire [1:0]   wr_trg_w  = {wr_w & hit_t2_w, wr_w & hit_t1_w};
   wire         wr_ts_w   = wr_w & hit_ts_w;

   wire [7:0]   ctl_rd_w [2];
   assign ctl_rd_w[0] = {ctrl_reg[0][7:6], out_reg[0], ctrl_reg[0][4:0]};
   assign ctl_rd_w[1] = {ctrl_reg[1][7:6], out_reg[1], ctrl_reg[1][4:0]};

   wire [31:0]  rd_mux_w  =
      hit_v1_w ? {16'h0000, value_reg[0]} :
      hit_c1_w ? {24'h000000, ctl_rd_w[0]} :
      hit_t1_w ? {28'h0000000, trig_reg[0]} :
      hit_v2_w ? {16'h0000, value_reg[1]} :
      hit_c2_w ? {24'h000000, ctl_rd_w[1]} :
      hit_t2_w ? {28'h0000000, trig_reg[1]} :
      hit_ts_w ? {24'h000000, tsel_reg} : 32'h00000000;

   // Read data is fetched in the setup cycle so it comes from a flop
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else if (setup_w) begin
         prdata_reg  <= pwrite_in ? 32'h00000000 : rd_mux_w;
         pslverr_reg <= ~mapped_w;
      end
   end

   assign prdata_out  = prdata_reg;
   assign pslverr_out = pslverr_reg;
   assign pready_out  = 1'b1;

   // Shared timer selection
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tsel_reg <= `TSEL_RESET;
      end else if (wr_ts_w) begin
         tsel_reg <= pwdata_in[7:0];
      end
   end

   // Trigger sources are asynchronous to this clock
   wire [8:0] raw_src_w = {logic_cell_result_in, pin_change_interrupt_in,
                           comparator_two_result_in, comparator_one_result_in,
                           input_remap_pin_in};
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_reg <= 9'h000;
         sync2_reg <= 9'h000;
      end else begin
         sync1_reg <= raw_src_w;
         sync2_reg <= sync1_reg;
      end
   end

   assign wide_timer_clear_out = clr_req_reg[0] | clr_req_reg[1];

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         logic        src_prev_reg;
         logic [3:0]  presc_reg;
         logic        match_prev_reg;
         duty_t       duty_buf_reg;
         logic        out_next;
         logic        irq_next;
         logic [1:0]  clr_next;

         wire [1:0]   choice_w  = tsel_reg[2*ch +: 2];
         wire         second_w  = (choice_w == `TSEL_SECOND);
         wire         en_w      = ctrl_reg[ch][`CTRL_EN_BIT];
         wire         left_w    = ctrl_reg[ch][`CTRL_ALIGN_BIT];
         wire [3:0]   mode_w    = ctrl_reg[ch][3:0];
         wire         on_w      = en_w & (mode_w != `MODE_OFF);
         wire         is_pwm_w  = (mode_w[3:2] == 2'h3);
         wire         is_cap_w  = (mode_w >= `MODE_CAP_ANY) &
                                  (mode_w <= `MODE_CAP_RISE16);
         chan_class_e cls_w;
         assign cls_w = !on_w ? CLASS_OFF :
                        is_pwm_w ? CLASS_PWM :
                        is_cap_w ? CLASS_CAPTURE : CLASS_COMPARE;

         // Capture source selection
         wire [7:0]   srcs_w    = {sync2_reg[8:4], sync2_reg[3:2], sync2_reg[ch]};
         wire         src_w     = trig_reg[ch][3] ? 1'b0 :
                                  srcs_w[trig_reg[ch][2:0]];
         wire         rise_w    = src_w & ~src_prev_reg;
         wire         fall_w    = ~src_w & src_prev_reg;
         wire         presc_on_w = (mode_w == `MODE_CAP_RISE4) |
                                   (mode_w == `MODE_CAP_RISE16);
         wire [3:0]   presc_last_w = (mode_w == `MODE_CAP_RISE4) ?
                                     `PRESC_LAST4 : `PRESC_LAST16;
         wire         cap_w     = (cls_w == CLASS_CAPTURE) & (
            ((mode_w == `MODE_CAP_ANY) & (rise_w | fall_w)) |
            ((mode_w == `MODE_CAP_FALL) & fall_w) |
            ((mode_w == `MODE_CAP_RISE) & rise_w) |
            (presc_on_w & rise_w & (presc_reg == presc_last_w)));

         // Wide timer for capture and compare
         wire [15:0]  wide_w    = second_w ? second_wide_timer_in :
                                  first_wide_timer_in;
         wire         match_w   = (cls_w == CLASS_COMPARE) &
                                  (wide_w == value_reg[ch]);
         wire         hit_w     = match_w & ~match_prev_reg;

         // Narrow timer and duty for PWM
         wire [9:0]   nbase_w   = second_w ? second_narrow_base_in :
                                  first_narrow_base_in;
         wire         nper_w    = second_w ? second_narrow_period_in :
                                  first_narrow_period_in;
         wire [9:0]   duty_w    = left_w ?
            {value_reg[ch][15:8], value_reg[ch][7:6]} :
            value_reg[ch][9:0];

         always_comb begin
            out_next = out_reg[ch];
            irq_next = 1'b0;
            clr_next = 2'h0;
            case (cls_w)
               CLASS_OFF: begin
                  out_next = 1'b0;
               end
               CLASS_CAPTURE: begin
                  irq_next = cap_w;
               end
               CLASS_COMPARE: begin
                  irq_next = hit_w;
                  if (hit_w) begin
                     case (mode_w)
                        `MODE_SET:       out_next = 1'b1;
                        `MODE_CLEAR:     out_next = 1'b0;
                        `MODE_TOGGLE:    out_next = ~out_reg[ch];
                        `MODE_TOG_CLR: begin
                           out_next = ~out_reg[ch];
                           clr_next = second_w ? 2'h2 : 2'h1;
                        end
                        `MODE_PULSE:     out_next = 1'b1;
                        `MODE_PULSE_CLR: begin
                           out_next = 1'b1;
                           clr_next = second_w ? 2'h2 : 2'h1;
                        end
                        default:         out_next = out_reg[ch];
                     endcase
                  end else if ((mode_w == `MODE_PULSE) |
                               (mode_w == `MODE_PULSE_CLR)) begin
                     out_next = 1'b0;
                  end
               end
               CLASS_PWM: begin
                  irq_next = nper_w;
                  if (nper_w) begin
                     out_next = (duty_w != 10'h000);
                  end else if (nbase_w == duty_buf_reg) begin
                     out_next = 1'b0;
                  end
               end
               default: begin
                  out_next = 1'b0;
               end
            endcase
         end

         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               ctrl_reg[ch] <= `CTRL_RESET;
               trig_reg[ch] <= `TRIG_RESET;
            end else begin
               if (wr_ctl_w[ch]) begin
                  ctrl_reg[ch] <= pwdata_in[7:0] & `CTRL_WR_MASK;
               end
               if (wr_trg_w[ch]) begin
                  trig_reg[ch] <= pwdata_in[3:0];
               end
            end
         end

         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               src_prev_reg   <= 1'b0;
               presc_reg      <= 4'h0;
               match_prev_reg <= 1'b0;
               duty_buf_reg   <= 10'h000;
               out_reg[ch]    <= 1'b0;
               irq_reg[ch]    <= 1'b0;
               clr_req_reg[ch] <= 2'h0;
            end else begin
               src_prev_reg   <= src_w;
               match_prev_reg <= match_w;
               out_reg[ch]    <= out_next;
               irq_reg[ch]    <= irq_next;
               clr_req_reg[ch] <= clr_next;
               if (!presc_on_w || cls_w != CLASS_CAPTURE) begin
                  presc_reg <= 4'h0;
               end else if (rise_w) begin
                  presc_reg <= (presc_reg == presc_last_w) ? 4'h0 :
                               presc_reg + 4'h1;
               end
               if (cls_w == CLASS_PWM && nper_w) begin
                  duty_buf_reg <= duty_w;
               end
            end
         end

         // No reset: contents survive every reset
         always_ff @(posedge clk_in) begin
            if (cap_w) begin
               value_reg[ch] <= wide_w;
            end else if (wr_val_w[ch]) begin
               value_reg[ch] <= pwdata_in[15:0];
            end
         end
      end
   endgenerate

   assign chan_out          = out_reg;
   assign chan_irq_flag_out = irq_reg;

endmodule

`default_nettype wire
